// file: design/ast_pkg.sv
/*
 * shared constants, register map and types of the async serial transceiver.
 * assumes a single pclk domain; all users import the whole package.
 */
package ast_pkg;
	// ==================================================
	// clocking and sizes
	localparam int OVERSAMPLE    = 16;
	localparam int TX_W          = 8;
	localparam int RX_W          = 11;
	localparam int TX_DEPTH      = 36;
	localparam int RX_DEPTH      = 36;
	localparam int RTS_MARGIN    = 4;
	localparam int TIMEOUT_CHARS = 4;
	localparam int CHAR_BITS     = 11;
	localparam int TIMEOUT_TICKS = TIMEOUT_CHARS * CHAR_BITS * OVERSAMPLE;
	localparam int TMO_W         = 10;
	localparam int AB_W          = 20;
	localparam int AB_SHIFT      = 4;
	localparam logic [3:0] SUB_MID   = 4'h7;
	localparam logic [3:0] SUB_LAST  = 4'hf;
	localparam logic [3:0] IR_NARROW = 4'h3;
	localparam logic [3:0] IR_WIDE   = 4'h4;
	localparam logic [2:0] BIT_BASE  = 3'h4;
	localparam logic [1:0] WLEN_MAX  = 2'h3;
	localparam int BRK_BIT = 10;
	localparam int FRM_BIT = 9;
	localparam int PAR_BIT = 8;
	// ==================================================
	// register map (byte addresses)
	localparam logic [7:0] OFF_DATA    = 8'h00;
	localparam logic [7:0] OFF_CTRL    = 8'h04;
	localparam logic [7:0] OFF_DIV     = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0c;
	localparam logic [7:0] OFF_INT_ST  = 8'h10;
	localparam logic [7:0] OFF_INT_CLR = 8'h14;
	localparam logic [7:0] OFF_INT_EN  = 8'h18;
	localparam logic [15:0] DIV_RESET  = 16'h0001;
	// ==================================================
	// events and interrupt identity codes
	localparam int EV_RXERR   = 0;
	localparam int EV_RXDATA  = 1;
	localparam int EV_TMO     = 2;
	localparam int EV_TXEMPTY = 3;
	localparam int EV_MODEM   = 4;
	localparam int EV_W       = 5;
	localparam logic [2:0] ID_NONE    = 3'h0;
	localparam logic [2:0] ID_RXERR   = 3'h1;
	localparam logic [2:0] ID_RXDATA  = 3'h2;
	localparam logic [2:0] ID_TMO     = 3'h3;
	localparam logic [2:0] ID_TXEMPTY = 3'h4;
	localparam logic [2:0] ID_MODEM   = 3'h5;
	// ==================================================
	// control register layout, msb first
	typedef struct packed {
		logic       flow_en;
		logic       autobaud;
		logic       ir_wide;
		logic       ir_en;
		logic       loopback;
		logic       fifo_mode;
		logic       even_par;
		logic       par_en;
		logic       stop2;
		logic [1:0] wlen;
	} ast_ctrl_type;
	localparam ast_ctrl_type CTRL_RESET = 11'h003; // 8 bits, no parity, legacy mode
	// ==================================================
	// helpers shared by transmitter and receiver
	function automatic logic [2:0] ast_last_bit(input logic [1:0] wlen);
		return BIT_BASE + {1'b0, wlen};
	endfunction
	function automatic logic ast_parity(input logic [7:0] d, input logic [1:0] wlen, input logic even);
		logic [7:0] m;
		m = 8'hff >> (WLEN_MAX - wlen);
		return (^(d & m)) ^ ~even;
	endfunction
endpackage

// file: design/ast_fifo_if.sv
/*
 * push/pop handshake bundle between the transceiver and its queues.
 * assumes both sides run on the same clock.
 */
`timescale 1ns/1ps
interface ast_fifo_if #(
	parameter int W     = 8,
	parameter int DEPTH = 36
);
	logic                       push_valid;
	logic                       push_ready;
	logic [W-1:0]               push_data;
	logic                       pop_valid;
	logic                       pop_ready;
	logic [W-1:0]               pop_data;
	logic [$clog2(DEPTH+1)-1:0] count;
	modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data, count);
	modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data, count);
endinterface

// file: design/ast_fifo.sv
/*
 * first-in first-out queue with valid/ready on both sides.
 * assumes the interface instance carries the same width and depth.
 */
`timescale 1ns/1ps
module ast_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 36
) (
	input wire logic pclk,
	input wire logic presetn,
	ast_fifo_if.store f
);
	import ast_pkg::*;
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           rd;
		logic [PW-1:0]           wr;
		logic [CW-1:0]           cnt;
	} ast_fifo_state_type;
	ast_fifo_state_type q;
	ast_fifo_state_type n;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] wrap(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
	endfunction

	// ==================================================
	// handshake and next state; a full queue refuses, never overwrites
	assign f.push_ready = (q.cnt != CW'(DEPTH));
	assign f.pop_valid  = (q.cnt != '0);
	assign f.pop_data   = q.mem[q.rd];
	assign f.count      = q.cnt;
	assign push         = f.push_valid & f.push_ready;
	assign pop          = f.pop_valid & f.pop_ready;

	always_comb
	begin
		n = q;
		if (push)
		begin
			n.mem[q.wr] = f.push_data;
			n.wr = wrap(q.wr);
		end
		if (pop)
			n.rd = wrap(q.rd);
		n.cnt = q.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= n;
	end
endmodule

// file: design/ast_rx.sv
/*
 * receiver: oversampling start detection, data, parity and stop sampling.
 * assumes tick pulses at sixteen times the bit rate and a decoded line.
 */
`timescale 1ns/1ps
module ast_rx (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  tick,
	input  wire logic                  line,
	input  wire ast_pkg::ast_ctrl_type cfg,
	output logic                       valid,
	output logic [ast_pkg::RX_W-1:0]   entry,
	output logic                       busy
);
	import ast_pkg::*;
	typedef enum logic [4:0] {
		RX_IDLE  = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA  = 5'b00100,
		RX_PAR   = 5'b01000,
		RX_STOP  = 5'b10000
	} ast_rx_state_type;
	typedef struct packed {
		ast_rx_state_type st;
		logic [3:0]       sub;
		logic [2:0]       bitn;
		logic [7:0]       sh;
		logic             perr;
		logic             valid;
		logic [RX_W-1:0]  entry;
	} ast_rx_reg_type;
	ast_rx_reg_type q;
	ast_rx_reg_type n;
	logic [7:0]     data;

	assign data  = q.sh >> (WLEN_MAX - cfg.wlen);
	assign valid = q.valid;
	assign entry = q.entry;
	assign busy  = (q.st != RX_IDLE);

	// ==================================================
	// character framing; each bit is read sixteen ticks after the previous sample, the first sixteen after the mid-start point
	always_comb
	begin
		n = q;
		n.valid = 1'b0;
		case (q.st)
			RX_IDLE:
				if (!line)
				begin
					n.st = RX_START;
					n.sub = '0;
				end
			RX_START:
				if (tick)
				begin
					n.sub = q.sub + 4'h1;
					if (q.sub == SUB_MID) // R17
					begin
						n.sub = '0;
						n.bitn = '0;
						n.perr = 1'b0;
						n.st = line ? RX_IDLE : RX_DATA; // R2
					end
				end
			RX_DATA:
				if (tick)
				begin
					n.sub = q.sub + 4'h1;
					if (q.sub == SUB_LAST) // R17
					begin
						n.sh = {line, q.sh[7:1]}; // R1
						n.bitn = q.bitn + 3'h1;
						if (q.bitn == ast_last_bit(cfg.wlen)) // R4
							n.st = cfg.par_en ? RX_PAR : RX_STOP;
					end
				end
			RX_PAR:
				if (tick)
				begin
					n.sub = q.sub + 4'h1;
					if (q.sub == SUB_LAST)
					begin
						n.perr = line ^ ast_parity(data, cfg.wlen, cfg.even_par); // R3
						n.st = RX_STOP;
					end
				end
			RX_STOP:
				if (tick)
				begin
					n.sub = q.sub + 4'h1;
					if (q.sub == SUB_LAST)
					begin
						n.valid = 1'b1;
						n.entry[7:0] = data; // R8
						n.entry[PAR_BIT] = q.perr; // R8
						n.entry[FRM_BIT] = ~line; // R2
						n.entry[BRK_BIT] = ~line & (data == '0); // R8
						n.st = RX_IDLE;
					end
				end
			default:
				n.st = RX_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '{st: RX_IDLE, default: '0};
		else
			q <= n;
	end
endmodule

// file: design/ast_top.sv
/*
 * async serial transceiver: apb registers, transmitter, queues, dma requests,
 * baud detection, receive timeout, modem lines, loopback and infrared coding.
 * assumes apb master on pclk, and serial and modem pins synchronous to pclk.
 */
// Operation
// (R1) Separate sections send bytes serially and turn received characters back into bytes.
// (R2) Every character carries a start bit before and stop bits after its data bits.
// (R3) With parity on, a parity bit is sent and a received mismatch is flagged.
// (R4) Data length is five to eight bits, parity optional, one or two stop bits.
// (R5) Reset selects the legacy one-deep mode; a queued mode is the other.
// (R6) One bit lasts sixteen ticks divided from the device clock.
// (R7) The transmit queue holds 36 bytes.
// (R8) A receive entry holds the byte in bits 7..0 and break, framing, parity flags in bits 10, 9, 8.
// (R9) Transmit and receive each have a dma request handshake.
// (R10) The bit rate can be measured from the received start bit and loaded into the divider.
// (R11) Received data left unread on a quiet line raises a timeout event.
// (R12) With flow control on, rts follows receive space and a high cts_n holds off transmit; rts_n rises at 32 queued entries, never reached in legacy mode.
// (R13) Modem inputs are readable and any change raises an event.
// (R14) In infrared mode a zero is a pulse of three or four sixteenths of a bit, decoded likewise.
// (R15) Loopback feeds the transmit line into the receiver and parks the pins.
// (R16) The highest pending source is reported: errors, data or timeout, tx empty, modem.
// (R17) Rx oversamples by sixteen, checks the start mid-bit, then samples bit centres.
`timescale 1ns/1ps
module ast_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             txd,
	input  wire logic        rxd,
	output logic             rts_n,
	input  wire logic        cts_n,
	input  wire logic        dsr_n,
	input  wire logic        dcd_n,
	input  wire logic        ri_n,
	output logic             irq,
	output logic             tx_dma_req,
	input  wire logic        tx_dma_ack,
	input  wire logic [7:0]  tx_dma_data,
	output logic             rx_dma_req,
	input  wire logic        rx_dma_ack,
	output logic [10:0]      rx_dma_data
);
	import ast_pkg::*;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_PAR   = 5'b01000,
		TX_STOP  = 5'b10000
	} ast_tx_state_type;
	typedef struct packed {
		ast_ctrl_type     ctrl;
		logic [15:0]      div;
		logic [EV_W-1:0]  ist;
		logic [EV_W-1:0]  ien;
		logic [3:0]       modem;
		logic [15:0]      tick_cnt;
		ast_tx_state_type tx_st;
		logic [3:0]       tx_sub;
		logic [2:0]       tx_bit;
		logic [7:0]       tx_sh;
		logic             tx_par;
		logic             tx_level;
		logic             tx_second;
		logic [3:0]       ir_cnt;
		logic [TMO_W-1:0] tmo_cnt;
		logic             ab_meas;
		logic [AB_W-1:0]  ab_cnt;
		logic [31:0]      prdata;
	} ast_top_state_type;
	ast_top_state_type q;
	ast_top_state_type n;

	ast_fifo_if #(.W(TX_W), .DEPTH(TX_DEPTH)) txf ();
	ast_fifo_if #(.W(RX_W), .DEPTH(RX_DEPTH)) rxf ();

	logic            tick;
	logic            wr;
	logic            rd;
	logic            tx_room;
	logic            rx_room;
	logic            tx_go;
	logic            tx_done;
	logic            ir_pulse;
	logic            line_out;
	logic            src;
	logic            line;
	logic            rx_valid;
	logic [RX_W-1:0] rx_entry;
	logic            rx_busy;
	logic [3:0]      modem_now;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;

	function automatic logic mapped(input logic [7:0] a);
		return a == OFF_DATA || a == OFF_CTRL || a == OFF_DIV || a == OFF_STATUS ||
			a == OFF_INT_ST || a == OFF_INT_CLR || a == OFF_INT_EN;
	endfunction

	function automatic logic [2:0] int_id(input logic [EV_W-1:0] p);
		if (p[EV_RXERR])
			return ID_RXERR;
		else if (p[EV_RXDATA])
			return ID_RXDATA;
		else if (p[EV_TMO])
			return ID_TMO;
		else if (p[EV_TXEMPTY])
			return ID_TXEMPTY;
		else if (p[EV_MODEM])
			return ID_MODEM;
		return ID_NONE;
	endfunction

	// ==================================================
	// queues and receiver
	ast_fifo #(.W(TX_W), .DEPTH(TX_DEPTH)) u_txq (.pclk(pclk), .presetn(presetn), .f(txf)); // R7
	ast_fifo #(.W(RX_W), .DEPTH(RX_DEPTH)) u_rxq (.pclk(pclk), .presetn(presetn), .f(rxf));
	ast_rx u_rx (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (tick),
		.line    (line),
		.cfg     (q.ctrl),
		.valid   (rx_valid),
		.entry   (rx_entry),
		.busy    (rx_busy)
	);

	// ==================================================
	// apb: zero wait states, read data latched in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign prdata  = q.prdata;
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & penable & ~pwrite;

	// legacy mode behaves as a single holding register in each direction
	assign tx_room = q.ctrl.fifo_mode ? txf.push_ready : (txf.count == '0); // R5
	assign rx_room = q.ctrl.fifo_mode ? rxf.push_ready : (rxf.count == '0); // R5

	// queue traffic; a cpu write and a dma ack in one cycle keep the dma byte
	assign txf.push_valid = ((wr & (paddr == OFF_DATA)) | tx_dma_ack) & tx_room;
	assign txf.push_data  = tx_dma_ack ? tx_dma_data : pwdata[TX_W-1:0];
	assign rxf.push_valid = rx_valid & rx_room;
	assign rxf.push_data  = rx_entry;
	assign rxf.pop_ready  = (rd & (paddr == OFF_DATA)) | rx_dma_ack;
	assign tx_dma_req     = tx_room; // R9
	assign rx_dma_req     = rxf.pop_valid; // R9
	assign rx_dma_data    = rxf.pop_data;

	// ==================================================
	// bit clock, line coding, loopback and pins
	assign tick      = (q.tick_cnt == '0); // R6
	assign tx_go     = (q.tx_st == TX_IDLE) & tick & txf.pop_valid & ~(q.ctrl.flow_en & cts_n); // R12
	assign txf.pop_ready = tx_go;
	assign tx_done   = tick & (q.tx_st == TX_STOP) & (q.tx_sub == SUB_LAST) & (q.tx_second | ~q.ctrl.stop2);
	assign ir_pulse  = ~q.tx_level & (q.tx_sub < (q.ctrl.ir_wide ? IR_WIDE : IR_NARROW)); // R14
	assign line_out  = q.ctrl.ir_en ? ir_pulse : q.tx_level;
	assign txd       = q.ctrl.loopback ? ~q.ctrl.ir_en : line_out; // R15
	assign src       = q.ctrl.loopback ? line_out : rxd; // R15
	assign line      = q.ctrl.ir_en ? ~(src | (q.ir_cnt != '0)) : src; // R14
	assign rts_n     = q.ctrl.loopback | (q.ctrl.flow_en & (rxf.count >= 6'(RX_DEPTH - RTS_MARGIN))); // R12
	assign modem_now = {cts_n, dsr_n, dcd_n, ri_n};
	assign irq       = |(q.ist & q.ien);

	// events; an event in the clearing cycle stays set
	assign ev[EV_RXERR]   = rx_valid & ((|rx_entry[BRK_BIT:PAR_BIT]) | ~rx_room); // R3
	assign ev[EV_RXDATA]  = rx_valid & rx_room;
	assign ev[EV_TMO]     = tick & (q.tmo_cnt == TMO_W'(TIMEOUT_TICKS - 1)); // R11
	assign ev[EV_TXEMPTY] = tx_done & ~txf.pop_valid;
	assign ev[EV_MODEM]   = (modem_now != q.modem); // R13
	assign clr = (wr & (paddr == OFF_INT_CLR)) ? pwdata[EV_W-1:0] : '0;

	// ==================================================
	// next state
	always_comb
	begin
		n = q;
		n.modem = modem_now;
		n.ist = (q.ist & ~clr) | ev;
		n.tick_cnt = tick ? q.div - 16'h0001 : q.tick_cnt - 16'h0001; // R6
		// register writes and read capture
		if (wr)
		begin
			case (paddr)
				OFF_CTRL:   n.ctrl = pwdata[$bits(ast_ctrl_type)-1:0];
				OFF_DIV:    n.div = (pwdata[15:0] == '0) ? DIV_RESET : pwdata[15:0];
				OFF_INT_EN: n.ien = pwdata[EV_W-1:0];
				default:    n.ien = q.ien;
			endcase
		end
		if (psel & ~penable)
		begin
			case (paddr)
				OFF_DATA:   n.prdata = 32'(rxf.pop_data); // R8
				OFF_CTRL:   n.prdata = 32'(q.ctrl);
				OFF_DIV:    n.prdata = 32'(q.div);
				OFF_STATUS: n.prdata = 32'({int_id(q.ist & q.ien), q.ab_meas, ~modem_now,
					q.tx_st != TX_IDLE, txf.count, rxf.count}); // R13 R16
				OFF_INT_ST: n.prdata = 32'(q.ist);
				OFF_INT_EN: n.prdata = 32'(q.ien);
				default:    n.prdata = '0;
			endcase
		end
		// transmitter: sixteen ticks per bit
		if (tx_go)
		begin
			n.tx_st = TX_START;
			n.tx_sh = txf.pop_data; // R1
			n.tx_par = ast_parity(txf.pop_data, q.ctrl.wlen, q.ctrl.even_par); // R3
			n.tx_level = 1'b0; // R2
			n.tx_sub = '0;
			n.tx_second = 1'b0;
		end
		else if (tick & (q.tx_st != TX_IDLE))
		begin
			n.tx_sub = q.tx_sub + 4'h1;
			if (q.tx_sub == SUB_LAST)
			begin
				case (q.tx_st)
					TX_START:
					begin
						n.tx_st = TX_DATA;
						n.tx_bit = '0;
						n.tx_level = q.tx_sh[0];
					end
					TX_DATA:
					begin
						n.tx_bit = q.tx_bit + 3'h1;
						n.tx_sh = q.tx_sh >> 1;
						n.tx_level = q.tx_sh[1];
						if (q.tx_bit == ast_last_bit(q.ctrl.wlen)) // R4
						begin
							n.tx_st = q.ctrl.par_en ? TX_PAR : TX_STOP; // R3
							n.tx_level = q.ctrl.par_en ? q.tx_par : 1'b1;
						end
					end
					TX_PAR:
					begin
						n.tx_st = TX_STOP;
						n.tx_level = 1'b1; // R2
					end
					TX_STOP:
					begin
						n.tx_second = 1'b1;
						if (tx_done) // R4
							n.tx_st = TX_IDLE;
					end
					default:
						n.tx_st = TX_IDLE;
				endcase
			end
		end
		// infrared receive: stretch each pulse to about one bit
		if (src)
			n.ir_cnt = SUB_LAST; // R14
		else if (tick & (q.ir_cnt != '0))
			n.ir_cnt = q.ir_cnt - 4'h1;
		// receive timeout counts quiet ticks while data waits
		if (rx_busy | rx_valid | ~rxf.pop_valid | rxf.pop_ready)
			n.tmo_cnt = '0; // R11
		else if (tick & (q.tmo_cnt != TMO_W'(TIMEOUT_TICKS)))
			n.tmo_cnt = q.tmo_cnt + TMO_W'(1);
		// baud detection measures one low start bit in pclk cycles
		if (q.ctrl.autobaud & ~q.ab_meas & ~line)
		begin
			n.ab_meas = 1'b1; // R10
			n.ab_cnt = '0;
		end
		else if (q.ab_meas)
		begin
			n.ab_cnt = q.ab_cnt + AB_W'(1);
			if (line)
			begin
				n.ab_meas = 1'b0;
				n.ctrl.autobaud = 1'b0;
				n.div = 16'(q.ab_cnt >> AB_SHIFT); // R10
				if (n.div == '0)
					n.div = DIV_RESET;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '{ctrl: CTRL_RESET, div: DIV_RESET, tx_st: TX_IDLE, tx_level: 1'b1,
				modem: 4'hf, default: '0}; // R5
		else
			q <= n;
	end
endmodule

// file: dv/ast_props.sv
/*
 * checker watching only the top ports.
 * assumes a bind to ast_top and the divider left at one for bit timing.
 */
`timescale 1ns/1ps
module ast_props
	import ast_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        txd,
	input wire logic        rts_n,
	input wire logic        cts_n,
	input wire logic        irq
);
	ast_ctrl_type ctl;
	logic [4:0]   ien;
	logic         div1;
	logic [7:0]   hi_cnt;
	logic         wr_acc;
	logic         mapped;
	assign wr_acc = psel && penable && pwrite && mapped;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= OFF_INT_EN;
	// ==================================================
	// shadow registers; a long high run on txd means the transmitter is idle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctl    <= CTRL_RESET;
			ien    <= 5'h00;
			div1   <= 1'b1;
			hi_cnt <= 8'h00;
		end
		else
		begin
			if (wr_acc && paddr == OFF_CTRL)
				ctl <= pwdata[10:0];
			if (wr_acc && paddr == OFF_INT_EN)
				ien <= pwdata[4:0];
			if (wr_acc && paddr == OFF_DIV)
				div1 <= pwdata[15:0] <= 16'h0001;
			hi_cnt <= !txd ? 8'h00 : (hi_cnt == 8'hff ? hi_cnt : hi_cnt + 8'h01);
		end
	// ==================================================
	// properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_bad_addr: assert property (psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access accepted");
	chk_err_access: assert property (pslverr |-> psel && penable && !mapped)
		else $error("stray error response");
	chk_clr_reads_zero: assert property (psel && penable && !pwrite && paddr == OFF_INT_CLR |-> prdata == 32'h0)
		else $error("clear register read not zero");
	chk_irq_masked: assert property (wr_acc && paddr == OFF_INT_EN && pwdata[4:0] == 5'h0 |=> !irq)
		else $error("irq while masked");
	chk_irq_needs_en: assert property (irq |-> ien != 5'h0)
		else $error("irq with no source enabled");
	chk_start_width: assert property (div1 && !ctl.ir_en && !ctl.loopback && $fell(txd) |->
		!txd [*8] ##1 !txd [*8]) else $error("zero bit too short");
	chk_loop_park: assert property (ctl.loopback && !ctl.ir_en |-> txd && rts_n)
		else $error("pins not parked");
	chk_rts_free: assert property (!ctl.flow_en && !ctl.loopback |-> !rts_n)
		else $error("rts high without flow control");
	chk_cts_hold: assert property (div1 && ctl.flow_en && !ctl.loopback && !ctl.ir_en && hi_cnt > 8'd200 &&
		$past(cts_n) && $past(cts_n, 2) && $past(cts_n, 3) |-> !$fell(txd)) else $error("start while cts high");
	chk_ir_pulse: assert property (div1 && ctl.ir_en && !ctl.loopback && $rose(txd) |->
		txd [*3] ##1 (ctl.ir_wide ? txd : !txd) ##1 !txd) else $error("bad infrared pulse");
	cov_unmapped: cover property (pslverr);
	cov_ir_pulse: cover property (ctl.ir_en && $rose(txd));
	cov_irq: cover property ($rose(irq));
endmodule

// file: dv/ast_remote.sv
/*
 * remote serial device: sends framed characters on rxd, decodes txd.
 * assumes sixteen pclk per bit, the divider left at one.
 */
`timescale 1ns/1ps
module ast_remote (
	input  wire logic pclk,
	input  wire logic txd,
	output logic      rxd
);
	int         nbits  = 8;
	logic       par_en = 1'b0;
	logic       stop2  = 1'b0;
	logic       listen = 1'b1;
	logic [9:0] got[$];
	initial rxd = 1'b1;
	// ==================================================
	// sender; bits change just after a rising edge
	task automatic bit_out(input logic b);
		rxd <= b;
		repeat (16) @(posedge pclk);
	endtask
	task automatic send(input logic [7:0] d, input logic p, input logic s);
		@(posedge pclk);
		bit_out(1'b0);
		for (int i = 0; i < nbits; i++)
			bit_out(d[i]);
		if (par_en)
			bit_out(p);
		bit_out(s);
		bit_out(1'b1);
	endtask
	// ==================================================
	// receiver samples on the falling clock, away from the launching edge
	initial
		forever
		begin
			logic [7:0] d;
			logic       p;
			logic       s;
			@(negedge txd iff listen);
			d = 8'h00;
			p = 1'b0;
			repeat (8) @(negedge pclk);
			for (int i = 0; i < nbits; i++)
			begin
				repeat (16) @(negedge pclk);
				d[i] = txd;
			end
			if (par_en)
			begin
				repeat (16) @(negedge pclk);
				p = txd;
			end
			repeat (16) @(negedge pclk);
			s = txd;
			if (stop2)
			begin
				repeat (16) @(negedge pclk);
				s = s & txd;
			end
			got.push_back({s, p, d});
		end
endmodule

// file: dv/async_serial_transceiver_tb.sv
/*
 * self-checking bench: apb master and remote partner.
 * assumes the divider at one, so one bit lasts sixteen pclk cycles.
 */
`timescale 1ns/1ps
module async_serial_transceiver_tb;
	import ast_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, rxd;
	logic        rts_n, cts_n, dsr_n, dcd_n, ri_n, irq, tx_dma_req, tx_dma_ack;
	logic        rx_dma_req, rx_dma_ack;
	logic [7:0]  paddr, tx_dma_data;
	logic [31:0] pwdata, prdata;
	logic [10:0] rx_dma_data;
	logic [64:0] exp_rd[$];
	logic [9:0]  exp_ch[$];
	int          bad_count = 0;
	int          total_checks = 0;
	ast_top ast_top_i (.*);
	ast_remote ast_remote_i (.pclk(pclk), .txd(txd), .rxd(rxd));
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, tx_dma_ack, rx_dma_ack, paddr, tx_dma_data, pwdata} = '0;
		{cts_n, dsr_n, dcd_n, ri_n} = 4'hf;
	end
	always #50 pclk = ~pclk;
	// ==================================================
	// reporting and comparison
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic flag(input string m);
		bad_count++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic cmp_rd(input logic [31:0] got, input logic err, input logic [64:0] e);
		total_checks++;
		if ((got & e[63:32]) !== e[31:0] || err !== e[64])
			flag("read data or response");
	endtask
	task automatic cmp_ch(input logic [9:0] got, input logic [9:0] e);
		total_checks++;
		if (got !== e)
			flag("serial character");
	endtask
	// ==================================================
	// apb master: holds the request until pready at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m = '1, input logic e = 1'b0);
		exp_rd.push_back({e, m, v});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic drain;
		while (exp_ch.size() != 0)
			@(posedge pclk);
		repeat (40) @(posedge pclk);
	endtask
	// reads judged mid access phase, once settled
	always @(negedge pclk)
		if (psel && penable && !pwrite)
		begin
			if (exp_rd.size() == 0)
				flag("read without a note");
			else
				cmp_rd(prdata, pslverr, exp_rd.pop_front());
		end
	// remote's decoded characters against the notes
	always @(posedge pclk)
		if (ast_remote_i.got.size() != 0)
		begin
			if (exp_ch.size() == 0)
				flag("character not expected");
			else
				cmp_ch(ast_remote_i.got.pop_front(), exp_ch.pop_front());
		end
	initial
	begin
		repeat (20000) @(posedge pclk);
		flag("watchdog expired");
		stop_test();
	end
	// ==================================================
	// scenarios
	initial
	begin
		int         k;
		logic [4:0] c;
		logic [7:0] d;
		logic [7:0] m;
		logic       p;
		void'($urandom(32'h13000103));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CTRL, 32'h003);
		rd(OFF_INT_EN, 32'h0);
		apb(1'b1, OFF_DIV, 32'h0);
		rd(OFF_DIV, 32'h1);
		rd(OFF_INT_CLR, 32'h0);
		rd(8'h1c, 32'h0, '1, 1'b1);
		// every length, parity kind and stop count, random data
		for (k = 0; k < 8; k++)
		begin
			c = {k[1] ^ k[0], k[2], k[1], k[1:0]};
			apb(1'b1, OFF_CTRL, {27'h1, c});
			ast_remote_i.nbits = 5 + k % 4;
			ast_remote_i.par_en = c[3];
			ast_remote_i.stop2 = c[2];
			m = 8'hff >> (3 - k % 4);
			d = 8'($urandom);
			p = c[3] && (c[4] ? ^(d & m) : ~^(d & m));
			exp_ch.push_back({1'b1, p, d & m});
			apb(1'b1, OFF_DATA, {24'h0, d});
			drain();
		end
		// transmit held off by cts, then released
		{ast_remote_i.nbits, ast_remote_i.par_en, ast_remote_i.stop2} = {32'd8, 2'b00};
		apb(1'b1, OFF_CTRL, 32'h423);
		d = 8'($urandom);
		apb(1'b1, OFF_DATA, {24'h0, d});
		repeat (300) @(posedge pclk);
		exp_ch.push_back({2'b10, d});
		cts_n <= 1'b0;
		drain();
		// loopback returns the byte to the receive queue
		d = 8'($urandom);
		apb(1'b1, OFF_CTRL, 32'h063);
		apb(1'b1, OFF_DATA, {24'h0, d});
		repeat (250) @(posedge pclk);
		rd(OFF_DATA, {24'h0, d});
		// good, parity error, framing error and break characters
		apb(1'b1, OFF_CTRL, 32'h03b);
		apb(1'b1, OFF_INT_CLR, 32'h1f);
		ast_remote_i.par_en = 1'b1;
		for (k = 0; k < 4; k++)
		begin
			d = (k == 3) ? 8'h00 : 8'($urandom) | 8'h01;
			ast_remote_i.send(d, ^d ^ (k == 1), k < 2);
			rd(OFF_DATA, {21'h0, k == 3, k > 1, k == 1, d});
		end
		// highest enabled source first, then cleared one by one
		apb(1'b1, OFF_INT_EN, 32'h1f);
		for (k = 0; k < 3; k++)
		begin
			rd(OFF_STATUS, (k == 2 ? 0 : k + 1) << 18, 32'h1c0000);
			apb(1'b1, OFF_INT_CLR, 32'h1 << k);
		end
		d = 8'($urandom);
		ast_remote_i.send(d, ^d, 1'b1);
		repeat (800) @(posedge pclk);
		cmp_rd({20'h0, rx_dma_req, rx_dma_data}, 1'b0, {1'b0, 32'hfff, 20'h0, 4'h8, d});
		rd(OFF_INT_ST, 32'h6, 32'h6);
		rd(OFF_DATA, {24'h0, d});
		dsr_n <= 1'b0;
		repeat (4) @(posedge pclk);
		rd(OFF_INT_ST, 32'h10, 32'h10);
		rd(OFF_STATUS, 32'h18000, 32'h1e000);
		apb(1'b1, OFF_INT_EN, 32'h0);
		exp_ch.push_back({1'b1, ^d, d});
		{tx_dma_data, tx_dma_ack} <= {d, tx_dma_req};
		@(posedge pclk);
		tx_dma_ack <= 1'b0;
		drain();
		// infrared pulses, narrow then wide; judged by the checker
		ast_remote_i.listen = 1'b0;
		for (k = 0; k < 2; k++)
		begin
			apb(1'b1, OFF_CTRL, 32'h0a3 | (k << 8));
			apb(1'b1, OFF_DATA, 32'h0);
			repeat (250) @(posedge pclk);
		end
		stop_test();
	end
endmodule
bind ast_top ast_props ast_props_i (.*);
